/* File: design/hwseq_pkg.sv */
// Package with register map, field layout, modes, states and timing for the waveform sequencer.
package hwseq_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_LIB = 8'h03;
  localparam logic [7:0] ADDR_SLOT_FIRST = 8'h04;
  localparam logic [7:0] ADDR_SLOT_LAST = 8'h0b;
  localparam logic [7:0] ADDR_FIRE = 8'h0c;

  // Reset values.
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] LIB_RESET = 3'h1;

  // Field layout of a slot and of the select fields.
  localparam int SLOT_WAIT_BIT = 7;
  localparam int SLOT_VAL_MSB = 6;
  localparam int SEL_MSB = 2;
  localparam int FIRE_BIT = 0;
  localparam int SLOT_COUNT = 8;
  localparam int SLOT_IDX_W = 3;
  localparam logic [2:0] SLOT_IDX_LAST = 3'h7;

  // Wait unit and clock rate; the cycle count is derived from both.
  localparam int WAIT_UNIT_MS = 10;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int WAIT_TICKS = WAIT_UNIT_MS * CLK_FREQ_KHZ;
  localparam int TICK_W = 20;

  // Operating modes selected by the mode field.
  typedef enum logic [2:0] {
    HWSEQ_MODE_INT_TRIG = 3'b000,
    HWSEQ_MODE_EXT_EDGE = 3'b001,
    HWSEQ_MODE_EXT_LEVEL = 3'b010,
    HWSEQ_MODE_PWM = 3'b011,
    HWSEQ_MODE_AUDIO = 3'b100,
    HWSEQ_MODE_RTP = 3'b101,
    HWSEQ_MODE_DIAG = 3'b110,
    HWSEQ_MODE_CAL = 3'b111
  } hwseq_mode_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    HWSEQ_ST_IDLE = 3'b000,
    HWSEQ_ST_FETCH = 3'b001,
    HWSEQ_ST_PLAY = 3'b010,
    HWSEQ_ST_WAIT = 3'b011,
    HWSEQ_ST_PROC = 3'b100
  } hwseq_state_e;

  // One register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hwseq_req_s;

endpackage : hwseq_pkg

/* File: design/hwseq_top.sv */
// Register-driven haptic waveform sequencer with fire control and trigger pin.
`timescale 1ns/1ps
module hwseq_top #(
  parameter int WAIT_TICKS = hwseq_pkg::WAIT_TICKS
) (
  // Clock, reset and clock enable.
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Register port.
  input wire hwseq_pkg::hwseq_req_s req_i,
  output logic [7:0] rdata_o,
  // External trigger pin.
  input wire logic trig_i,
  // Waveform playback engine.
  output logic play_active_o,
  output logic [6:0] play_index_o,
  output logic [2:0] play_lib_o,
  input wire logic play_done_i,
  // Calibration and diagnostic engines.
  output logic cal_active_o,
  output logic diag_active_o,
  input wire logic proc_done_i,
  // Status.
  output logic busy_o
);

  // Decodes an address inside the slot window.
  function automatic logic is_slot(input logic [7:0] a);
    is_slot = (a >= hwseq_pkg::ADDR_SLOT_FIRST) && (a <= hwseq_pkg::ADDR_SLOT_LAST);
  endfunction : is_slot

  // Register state.
  logic [7:0] slot [hwseq_pkg::SLOT_COUNT];
  logic [7:0] next_slot [hwseq_pkg::SLOT_COUNT];
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic [2:0] lib;
  logic [2:0] next_lib;
  logic go;
  logic next_go;
  logic trig_q;
  logic next_trig_q;
  logic [7:0] next_rdata;

  // Sequencer state.
  hwseq_pkg::hwseq_state_e state;
  hwseq_pkg::hwseq_state_e next_state;
  logic [2:0] idx;
  logic [2:0] next_idx;
  logic [6:0] wait_val;
  logic [6:0] next_wait_val;
  logic [6:0] steps;
  logic [6:0] next_steps;
  logic [hwseq_pkg::TICK_W-1:0] tick;
  logic [hwseq_pkg::TICK_W-1:0] next_tick;
  logic [6:0] index;
  logic [6:0] next_index;
  logic [2:0] lib_lat;
  logic [2:0] next_lib_lat;
  logic fin;
  logic [7:0] code;
  logic [2:0] waddr_idx;

  // Tick counter width taken locally so that the size casts below stay plain.
  localparam int TW = hwseq_pkg::TICK_W;
  localparam logic [TW-1:0] TICK_LAST = TW'(WAIT_TICKS - 1);
  localparam logic [TW-1:0] TICK_ONE = TW'(1);

  assign waddr_idx = 3'(req_i.addr - hwseq_pkg::ADDR_SLOT_FIRST);
  assign code = slot[idx];

  // Register writes, trigger pin handling and fire bit update.
  always_comb begin
    logic sw_set;
    logic sw_clr;
    logic pin_set;
    logic pin_clr;
    sw_set = 1'b0;
    sw_clr = 1'b0;
    pin_set = 1'b0;
    pin_clr = 1'b0;
    next_slot = slot;
    next_mode = mode;
    next_lib = lib;
    next_trig_q = trig_i;
    next_rdata = 8'h00;
    if (req_i.wr) begin
      if (is_slot(req_i.addr)) begin
        next_slot[waddr_idx] = req_i.wdata;
      end
      if (req_i.addr == hwseq_pkg::ADDR_MODE) begin
        next_mode = req_i.wdata[hwseq_pkg::SEL_MSB:0];
      end
      if (req_i.addr == hwseq_pkg::ADDR_LIB) begin
        next_lib = req_i.wdata[hwseq_pkg::SEL_MSB:0];
      end
      if (req_i.addr == hwseq_pkg::ADDR_FIRE) begin
        sw_set = req_i.wdata[hwseq_pkg::FIRE_BIT];
        sw_clr = !req_i.wdata[hwseq_pkg::FIRE_BIT];
      end
    end
    // The trigger pin drives the fire bit in the external modes.
    if (mode == hwseq_pkg::HWSEQ_MODE_EXT_EDGE) begin
      pin_set = trig_i && !trig_q;
    end else if (mode == hwseq_pkg::HWSEQ_MODE_EXT_LEVEL) begin
      pin_set = trig_i && !trig_q;
      pin_clr = !trig_i && trig_q;
    end
    // Any set wins over a clear or a self-clear in the same cycle.
    if (sw_set || pin_set) begin
      next_go = 1'b1;
    end else if (sw_clr || pin_clr || fin) begin
      next_go = 1'b0;
    end else begin
      next_go = go;
    end
    if (req_i.rd) begin
      if (is_slot(req_i.addr)) begin
        next_rdata = slot[3'(req_i.addr - hwseq_pkg::ADDR_SLOT_FIRST)];
      end else if (req_i.addr == hwseq_pkg::ADDR_MODE) begin
        next_rdata = {5'h00, mode};
      end else if (req_i.addr == hwseq_pkg::ADDR_LIB) begin
        next_rdata = {5'h00, lib};
      end else if (req_i.addr == hwseq_pkg::ADDR_FIRE) begin
        next_rdata = {7'h00, go};
      end
    end
  end

  // Registers the register group.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < hwseq_pkg::SLOT_COUNT; i++) begin
        slot[i] <= hwseq_pkg::SLOT_RESET;
      end
      mode <= hwseq_pkg::MODE_RESET;
      lib <= hwseq_pkg::LIB_RESET;
      go <= 1'b0;
      trig_q <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      slot <= next_slot;
      mode <= next_mode;
      lib <= next_lib;
      go <= next_go;
      trig_q <= next_trig_q;
      rdata_o <= next_rdata;
    end
  end

  // Sequencer next state: slot walk, waits and process launch.
  always_comb begin
    logic advance;
    advance = 1'b0;
    fin = 1'b0;
    next_state = state;
    next_idx = idx;
    next_wait_val = wait_val;
    next_steps = steps;
    next_tick = tick;
    next_index = index;
    next_lib_lat = lib_lat;
    case (state)
      hwseq_pkg::HWSEQ_ST_IDLE: begin
        if (go) begin
          next_lib_lat = lib;
          next_idx = '0;
          case (mode)
            hwseq_pkg::HWSEQ_MODE_INT_TRIG, hwseq_pkg::HWSEQ_MODE_EXT_EDGE,
            hwseq_pkg::HWSEQ_MODE_EXT_LEVEL: begin
              next_state = hwseq_pkg::HWSEQ_ST_FETCH;
            end
            hwseq_pkg::HWSEQ_MODE_DIAG, hwseq_pkg::HWSEQ_MODE_CAL: begin
              next_state = hwseq_pkg::HWSEQ_ST_PROC;
            end
            default: begin
              next_state = hwseq_pkg::HWSEQ_ST_IDLE;
            end
          endcase
        end
      end
      hwseq_pkg::HWSEQ_ST_FETCH: begin
        if (code == hwseq_pkg::SLOT_RESET) begin
          fin = 1'b1;
        end else if (code[hwseq_pkg::SLOT_WAIT_BIT]) begin
          next_wait_val = code[hwseq_pkg::SLOT_VAL_MSB:0];
          next_steps = '0;
          next_tick = '0;
          if (code[hwseq_pkg::SLOT_VAL_MSB:0] == 7'h00) begin
            advance = 1'b1;
          end else begin
            next_state = hwseq_pkg::HWSEQ_ST_WAIT;
          end
        end else begin
          next_index = code[hwseq_pkg::SLOT_VAL_MSB:0];
          next_state = hwseq_pkg::HWSEQ_ST_PLAY;
        end
      end
      hwseq_pkg::HWSEQ_ST_PLAY: begin
        advance = play_done_i;
      end
      hwseq_pkg::HWSEQ_ST_WAIT: begin
        // Each tick period is one wait unit; the wait ends after wait_val units.
        if (tick == TICK_LAST) begin
          next_tick = '0;
          next_steps = steps + 7'h01;
          advance = (steps + 7'h01) == wait_val;
        end else begin
          next_tick = tick + TICK_ONE;
        end
      end
      hwseq_pkg::HWSEQ_ST_PROC: begin
        fin = proc_done_i;
      end
      default: begin
        next_state = hwseq_pkg::HWSEQ_ST_IDLE;
      end
    endcase
    if (advance) begin
      if (idx == hwseq_pkg::SLOT_IDX_LAST) begin
        fin = 1'b1;
      end else begin
        next_idx = idx + 3'h1;
        next_state = hwseq_pkg::HWSEQ_ST_FETCH;
      end
    end
    if (fin) begin
      next_state = hwseq_pkg::HWSEQ_ST_IDLE;
    end
    // A cleared fire bit cancels whatever is running.
    if (state != hwseq_pkg::HWSEQ_ST_IDLE && !go) begin
      fin = 1'b0;
      next_state = hwseq_pkg::HWSEQ_ST_IDLE;
    end
  end

  // Registers the sequencer group.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= hwseq_pkg::HWSEQ_ST_IDLE;
      idx <= '0;
      wait_val <= '0;
      steps <= '0;
      tick <= '0;
      index <= '0;
      lib_lat <= hwseq_pkg::LIB_RESET;
    end else if (ce_i) begin
      state <= next_state;
      idx <= next_idx;
      wait_val <= next_wait_val;
      steps <= next_steps;
      tick <= next_tick;
      index <= next_index;
      lib_lat <= next_lib_lat;
    end
  end

  // Engine outputs.
  assign play_active_o = (state == hwseq_pkg::HWSEQ_ST_PLAY) && go;
  assign play_index_o = index;
  assign play_lib_o = lib_lat;
  assign cal_active_o = (state == hwseq_pkg::HWSEQ_ST_PROC) && go &&
                        (mode == hwseq_pkg::HWSEQ_MODE_CAL);
  assign diag_active_o = (state == hwseq_pkg::HWSEQ_ST_PROC) && go &&
                         (mode == hwseq_pkg::HWSEQ_MODE_DIAG);
  assign busy_o = state != hwseq_pkg::HWSEQ_ST_IDLE;

  // Checks of the sequencer behaviour.
  a_wait_no_play: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == hwseq_pkg::HWSEQ_ST_WAIT |-> !play_active_o && wait_val != 7'h00)
    else $error("play active during wait slot");
  a_wait_step_bound: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == hwseq_pkg::HWSEQ_ST_WAIT |-> steps < wait_val && tick <= TICK_LAST)
    else $error("wait ran past its length");
  a_index_from_slot: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && state == hwseq_pkg::HWSEQ_ST_FETCH && go && code != hwseq_pkg::SLOT_RESET &&
    !code[hwseq_pkg::SLOT_WAIT_BIT] |=> state == hwseq_pkg::HWSEQ_ST_PLAY &&
    play_index_o == $past(code[hwseq_pkg::SLOT_VAL_MSB:0]))
    else $error("index not taken from slot");
  a_start_first: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && state == hwseq_pkg::HWSEQ_ST_IDLE && go && mode == hwseq_pkg::HWSEQ_MODE_INT_TRIG
    |=> idx == 3'h0 && state == hwseq_pkg::HWSEQ_ST_FETCH)
    else $error("playback did not start at first slot");
  a_slot_advance: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && play_active_o && play_done_i && idx != hwseq_pkg::SLOT_IDX_LAST |=>
    idx == $past(idx) + 3'h1)
    else $error("slot did not advance");
  a_end_clears: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && state == hwseq_pkg::HWSEQ_ST_FETCH && go && code == 8'h00 && !req_i.wr
    && mode == hwseq_pkg::HWSEQ_MODE_INT_TRIG |=> !go && !busy_o)
    else $error("zero slot did not end sequence");
  a_abort_idle: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ce_i && busy_o && !go |=> !busy_o)
    else $error("cleared fire bit did not abort");
  a_lib_held: assert property (@(posedge core_clk_i) disable iff (reset_i)
    busy_o && $past(busy_o) |-> $stable(lib_lat))
    else $error("library changed during playback");
  a_proc_mode: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cal_active_o |-> !diag_active_o && !play_active_o && mode == hwseq_pkg::HWSEQ_MODE_CAL)
    else $error("calibration active in wrong mode");
  c_wait_slot: cover property (@(posedge core_clk_i) state == hwseq_pkg::HWSEQ_ST_WAIT);
  c_full_walk: cover property (@(posedge core_clk_i) play_active_o && play_done_i &&
    idx == hwseq_pkg::SLOT_IDX_LAST);
  c_abort: cover property (@(posedge core_clk_i) busy_o && !go);
  c_cal_run: cover property (@(posedge core_clk_i) cal_active_o && proc_done_i);

endmodule : hwseq_top

/* File: test/hwseq_engine_model.sv */
// Behavioural playback, calibration and diagnostic engines answering the sequencer.
`timescale 1ns/1ps
module hwseq_engine_model (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Activity from the sequencer and answer delay in cycles.
  input wire logic play_active_i,
  input wire logic proc_active_i,
  input wire logic [7:0] delay_i,
  // Completion pulses back to the sequencer.
  output logic play_done_o,
  output logic proc_done_o
);
  logic [7:0] cnt;

  // Counts active cycles and pulses done once per run, or every cycle from 8'hff on if delay_i is 8'hff; a dropped request restarts the count.
  always_ff @(posedge core_clk_i) begin
    play_done_o <= 1'b0;
    proc_done_o <= 1'b0;
    if (reset_i || !(play_active_i || proc_active_i)) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
      if (cnt == delay_i) begin
        play_done_o <= play_active_i;
        proc_done_o <= proc_active_i;
      end
    end
  end
endmodule : hwseq_engine_model

/* File: test/hwseq_top_bench.sv */
// Self-checking bench for the haptic waveform sequencer.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %0t %s", $time, m); end end
module hwseq_top_bench;
  localparam int WT = 4;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  hwseq_pkg::hwseq_req_s req = '0;
  logic trig = 1'b0;
  logic ce = 1'b1;
  logic [7:0] dly = 8'h03;
  logic [7:0] rdata, rv;
  logic play_active, cal_active, diag_active, play_done, proc_done, busy;
  logic [6:0] play_index;
  logic [2:0] play_lib;
  logic [6:0] idx_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  // Free-running core clock.
  always #5 core_clk_i = ~core_clk_i;

  hwseq_top #(.WAIT_TICKS(WT)) u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce),
    .req_i(req), .rdata_o(rdata), .trig_i(trig), .play_active_o(play_active),
    .play_index_o(play_index), .play_lib_o(play_lib), .play_done_i(play_done),
    .cal_active_o(cal_active), .diag_active_o(diag_active), .proc_done_i(proc_done),
    .busy_o(busy));

  hwseq_engine_model u_eng (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .play_active_i(play_active), .proc_active_i(cal_active | diag_active), .delay_i(dly),
    .play_done_o(play_done), .proc_done_o(proc_done));

  // Records the index of every waveform that finishes, and cuts a hang short.
  always @(posedge core_clk_i) begin
    if (play_done === 1'b1 && play_active === 1'b1) idx_q.push_back(play_index);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED %0t timeout", $time);
      final_report();
    end
  end

  // One-cycle register write and read strobes.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk_i);
    req = '0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk_i);
    req = '0;
    d = rdata;
  endtask : reg_rd

  // Loads all eight slots, lowest byte into the first slot.
  task automatic load(input logic [63:0] v);
    for (int i = 0; i < 8; i++) reg_wr(hwseq_pkg::ADDR_SLOT_FIRST + 8'(i), v[8*i +: 8]);
  endtask : load
  task automatic start(input logic [7:0] m, input logic [7:0] d);
    dly = d;
    idx_q.delete();
    reg_wr(hwseq_pkg::ADDR_MODE, m);
    reg_wr(hwseq_pkg::ADDR_FIRE, 8'h01);
    repeat (2) @(negedge core_clk_i);
  endtask : start
  task automatic wait_act();
    for (int i = 0; i < 50 && play_active !== 1'b1; i++) @(negedge core_clk_i);
    `CHK(play_active, 1'b1, "waveform did not start")
  endtask : wait_act
  task automatic wait_idle();
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge core_clk_i);
    `CHK(busy, 1'b0, "sequencer did not go idle")
    reg_rd(hwseq_pkg::ADDR_FIRE, rv);
    `CHK(rv, 8'h00, "fire bit not cleared")
  endtask : wait_idle

  // Reset values, read-back, masked fields and an unmapped address.
  task automatic t_regs();
    for (int a = 0; a < 16; a++) begin
      reg_rd(8'(a), rv);
      `CHK(rv, (a == 3) ? 8'h01 : 8'h00, "reset value")
    end
    for (int i = 0; i < 8; i++) begin
      reg_wr(hwseq_pkg::ADDR_SLOT_FIRST + 8'(i), 8'h11 * 8'(i + 1));
      reg_rd(hwseq_pkg::ADDR_SLOT_FIRST + 8'(i), rv);
      `CHK(rv, 8'h11 * 8'(i + 1), "slot read-back")
    end
    reg_wr(8'h02, 8'hff);
    reg_rd(8'h02, rv);
    `CHK(rv, 8'h00, "unmapped address")
    reg_wr(hwseq_pkg::ADDR_MODE, 8'hff);
    reg_rd(hwseq_pkg::ADDR_MODE, rv);
    `CHK(rv, 8'h07, "mode field width")
    reg_wr(hwseq_pkg::ADDR_LIB, 8'hf9);
    reg_rd(hwseq_pkg::ADDR_LIB, rv);
    `CHK(rv, 8'h01, "library field width")
  endtask : t_regs

  // A low clock enable freezes the registers, so writes and a fire are lost.
  task automatic t_ce();
    ce = 1'b0;
    reg_wr(hwseq_pkg::ADDR_LIB, 8'h02);
    reg_wr(hwseq_pkg::ADDR_FIRE, 8'h01);
    ce = 1'b1;
    reg_rd(hwseq_pkg::ADDR_LIB, rv);
    `CHK(rv, 8'h01, "library write while frozen")
    reg_rd(hwseq_pkg::ADDR_FIRE, rv);
    `CHK(rv, 8'h00, "fire write while frozen")
    `CHK(busy, 1'b0, "sequencer started while frozen")
  endtask : t_ce

  // Waveform, wait of three units, waveform, then a zero slot ends it.
  task automatic t_seq();
    int n;
    load(64'h0000_0000_0007_8305);
    start(8'h00, 8'h08);
    wait_act();
    `CHK(play_index, 7'h05, "first slot index")
    `CHK(play_lib, 3'h1, "library at fire")
    reg_rd(hwseq_pkg::ADDR_FIRE, rv);
    `CHK(rv, 8'h01, "fire bit while playing")
    for (int i = 0; i < 50 && play_done !== 1'b1; i++) @(negedge core_clk_i);
    @(negedge core_clk_i);
    n = 0;
    while (play_active !== 1'b1 && n < 200) begin
      n++;
      @(negedge core_clk_i);
    end
    `CHK(n, 3 * WT + 2, "wait slot length")
    `CHK(play_index, 7'h07, "index after wait")
    wait_idle();
    `CHK(idx_q.size(), 2, "waveforms played")
  endtask : t_seq

  // All eight slots filled: played in order, then the run stops.
  task automatic t_eight();
    load(64'h0807_0605_0403_0201);
    start(8'h00, 8'h01);
    wait_idle();
    `CHK(idx_q.size(), 8, "eight slots played")
    foreach (idx_q[i]) `CHK(idx_q[i], 7'(i + 1), "slot order")
  endtask : t_eight

  // A zero first slot ends the run at once.
  task automatic t_zero();
    load(64'h0);
    start(8'h00, 8'h01);
    wait_idle();
    `CHK(idx_q.size(), 0, "zero first slot")
  endtask : t_zero

  // Clearing fire mid-waveform drops play_active at once and busy one cycle later.
  task automatic t_abort();
    load(64'h0605);
    start(8'h00, 8'h28);
    wait_act();
    reg_wr(hwseq_pkg::ADDR_FIRE, 8'h00);
    `CHK(play_active, 1'b0, "abort output")
    @(negedge core_clk_i);
    `CHK(busy, 1'b0, "abort busy")
    `CHK(idx_q.size(), 0, "abort played")
  endtask : t_abort

  // Library is latched when fire is set and ignores later writes.
  task automatic t_lib();
    load(64'h09);
    reg_wr(hwseq_pkg::ADDR_LIB, 8'h03);
    start(8'h00, 8'h08);
    wait_act();
    reg_wr(hwseq_pkg::ADDR_LIB, 8'h05);
    `CHK(play_lib, 3'h3, "latched library")
    `CHK(play_index, 7'h09, "index in library")
    wait_idle();
  endtask : t_lib

  // Calibration, diagnostics and a mode with no process here.
  task automatic t_proc();
    logic [7:0] m;
    for (int k = 0; k < 2; k++) begin
      m = 8'h07 - 8'(k);
      start(m, 8'h05);
      `CHK(cal_active, m == 8'h07, "calibration start")
      `CHK(diag_active, m == 8'h06, "diagnostic start")
      `CHK(play_active, 1'b0, "no playback in process mode")
      wait_idle();
    end
    start(8'h03, 8'h05);
    reg_rd(hwseq_pkg::ADDR_FIRE, rv);
    `CHK(rv, 8'h01, "fire held in other mode")
    `CHK(play_active, 1'b0, "no playback in other mode")
    reg_wr(hwseq_pkg::ADDR_FIRE, 8'h00);
  endtask : t_proc

  // Pin sets and clears fire in level mode, sets it in edge mode.
  task automatic t_trig();
    load(64'h05);
    dly = 8'h28;
    reg_wr(hwseq_pkg::ADDR_MODE, 8'h02);
    trig = 1'b1;
    wait_act();
    trig = 1'b0;
    repeat (2) @(negedge core_clk_i);
    `CHK(play_active, 1'b0, "pin clears fire")
    wait_idle();
    dly = 8'h02;
    idx_q.delete();
    reg_wr(hwseq_pkg::ADDR_MODE, 8'h01);
    trig = 1'b1;
    repeat (3) @(negedge core_clk_i);
    wait_idle();
    `CHK(idx_q.size(), 1, "pin edge fires once")
    trig = 1'b0;
  endtask : t_trig

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Main sequence.
  initial begin
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    t_regs();
    t_ce();
    t_seq();
    t_eight();
    t_zero();
    t_abort();
    t_lib();
    t_proc();
    t_trig();
    final_report();
  end
endmodule : hwseq_top_bench
